// ### verilog/pdrm_pkg.sv
// Package for the power-down and reference monitor register bank
package pdrm_pkg;
    // Register addresses on the serial port's internal byte bus
    localparam logic [15:0] ADDR_XTAL_CTRL   = 16'h00b4;
    localparam logic [15:0] ADDR_REF_DIS     = 16'h00b5;
    localparam logic [15:0] ADDR_PD_RSVD     = 16'h00b6;
    localparam logic [15:0] ADDR_OUT_DIS     = 16'h00b7;
    localparam logic [15:0] ADDR_LOOP_DIS    = 16'h00b8;
    localparam logic [15:0] ADDR_MON_RSVD0   = 16'h00b9;
    localparam logic [15:0] ADDR_REF0_HIGH   = 16'h00ba;
    localparam logic [15:0] ADDR_REF0_LOW    = 16'h00bb;
    localparam logic [15:0] ADDR_REF1_TOP    = 16'h00bc;
    localparam logic [15:0] ADDR_REF1_HIGH   = 16'h00bd;
    localparam logic [15:0] ADDR_REF1_LOW    = 16'h00be;

    // Field positions
    localparam int POS_DOUBLER_BYPASS = 0;
    localparam int POS_DIGITAL_OFF    = 2;
    localparam int POS_CAL_HOLD       = 0;
    localparam int POS_LIMIT_TOP      = 0;

    // Reset values
    localparam logic        RST_DOUBLER_BYPASS = 1'b0;
    localparam logic [1:0]  RST_REF_INPUT_OFF  = 2'h3;
    localparam logic [7:0]  RST_OUT_DRIVER_OFF = 8'hf0;
    localparam logic        RST_DIGITAL_OFF    = 1'b1;
    localparam logic        RST_CAL_HOLD       = 1'b1;
    localparam logic [16:0] RST_MISS_LIMIT     = 17'h00000;
    // Least usable limit, software's duty to honour
    localparam logic [16:0] MIN_MISS_LIMIT     = 17'h00003;

    // Host-side access from the serial port engine
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } pdrm_access_t;

    // Controls delivered to the clocking core
    typedef struct packed {
        logic        xtal_doubler_bypass;
        logic [1:0]  ref_input_off;
        logic [7:0]  out_driver_off;
        logic        digital_loop_off;
        logic        analog_cal_hold;
        logic [16:0] ref0_miss_limit;
        logic [16:0] ref1_miss_limit;
    } pdrm_ctrl_t;
endpackage

// ### verilog/pdrm_regs.sv
// Power-down controls and reference miss limits, byte registers for the serial port
`timescale 1ns/1ns
// What this block does
// - Doubler bypass 0 feeds twice the crystal frequency to the loop, 1 feeds it unchanged, reset 0.
// - Digital loop off bit turns the digital loop off at 1 and on at 0, reset 1.
// - Analog calibration hold bit keeps calibration disabled at 1 and allowed at 0, reset 1.
// - Reference 1 has a 17-bit miss limit and reference 0 a 16-bit one (bit 16 held at 0), in monitor clock periods before a soft alarm, reset 0.
module pdrm_regs (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire pdrm_pkg::pdrm_access_t acc,
    output logic [7:0]                 rdata,
    output logic                       rvalid,
    output logic                       hit,
    output pdrm_pkg::pdrm_ctrl_t       ctrl,
    output logic                       limit_below_min
);
    // Stored fields; reference 0 has no bit 16 register
    logic        doubler_bypass;
    logic [1:0]  ref_off;
    logic [7:0]  drv_off;
    logic        dig_off;
    logic        cal_hold;
    logic [7:0]  lim0_high;
    logic [7:0]  lim0_low;
    logic        lim1_top;
    logic [7:0]  lim1_high;
    logic [7:0]  lim1_low;

    // Write strobes, one per stored byte
    logic        w_xtal;
    logic        w_ref;
    logic        w_out;
    logic        w_loop;
    logic        w_r0h;
    logic        w_r0l;
    logic        w_r1t;
    logic        w_r1h;
    logic        w_r1l;
    logic        in_bank;

    logic        next_doubler_bypass;
    logic [1:0]  next_ref_off;
    logic [7:0]  next_drv_off;
    logic        next_dig_off;
    logic        next_cal_hold;
    logic        next_lim1_top;
    logic [7:0]  next_lim_byte;

    logic [7:0]  rd_xtal;
    logic [7:0]  rd_ref;
    logic [7:0]  rd_out;
    logic [7:0]  rd_loop;
    logic [7:0]  rd_r0h;
    logic [7:0]  rd_r0l;
    logic [7:0]  rd_r1t;
    logic [7:0]  rd_r1h;
    logic [7:0]  rd_r1l;
    logic [7:0]  next_rdata;
    logic        next_rvalid;
    logic [16:0] lim0;
    logic [16:0] lim1;

    function automatic logic byte_write(input pdrm_pkg::pdrm_access_t a,
                                        input logic [15:0]            target);
        return a.wr && (a.addr == target);
    endfunction

    function automatic logic in_bank_range(input logic [15:0] addr);
        return (addr >= pdrm_pkg::ADDR_XTAL_CTRL) && (addr <= pdrm_pkg::ADDR_REF1_LOW);
    endfunction

    // One field bit in an otherwise empty byte
    function automatic logic [7:0] bit_at(input logic        value,
                                          input int unsigned pos);
        logic [7:0] placed;
        placed           = 8'h00;
        placed[pos[2:0]] = value;
        return placed;
    endfunction

    // Below three periods a slow edge cannot be told from a lost one
    function automatic logic limit_too_small(input logic [16:0] limit);
        return limit < pdrm_pkg::MIN_MISS_LIMIT;
    endfunction

    assign w_xtal  = byte_write(acc, pdrm_pkg::ADDR_XTAL_CTRL);
    assign w_ref   = byte_write(acc, pdrm_pkg::ADDR_REF_DIS);
    assign w_out   = byte_write(acc, pdrm_pkg::ADDR_OUT_DIS);
    assign w_loop  = byte_write(acc, pdrm_pkg::ADDR_LOOP_DIS);
    assign w_r0h   = byte_write(acc, pdrm_pkg::ADDR_REF0_HIGH);
    assign w_r0l   = byte_write(acc, pdrm_pkg::ADDR_REF0_LOW);
    assign w_r1t   = byte_write(acc, pdrm_pkg::ADDR_REF1_TOP);
    assign w_r1h   = byte_write(acc, pdrm_pkg::ADDR_REF1_HIGH);
    assign w_r1l   = byte_write(acc, pdrm_pkg::ADDR_REF1_LOW);
    assign in_bank = in_bank_range(acc.addr);
    assign hit     = in_bank;

    // Reserved write bits are dropped here, never stored
    assign next_doubler_bypass = acc.wdata[pdrm_pkg::POS_DOUBLER_BYPASS];
    assign next_ref_off        = acc.wdata[1:0];
    assign next_drv_off        = acc.wdata;
    assign next_dig_off        = acc.wdata[pdrm_pkg::POS_DIGITAL_OFF];
    assign next_cal_hold       = acc.wdata[pdrm_pkg::POS_CAL_HOLD];
    assign next_lim1_top       = acc.wdata[pdrm_pkg::POS_LIMIT_TOP];
    assign next_lim_byte       = acc.wdata;

    assign rd_xtal = bit_at(doubler_bypass, pdrm_pkg::POS_DOUBLER_BYPASS);
    assign rd_ref  = {6'h00, ref_off};
    assign rd_out  = drv_off;
    assign rd_loop = bit_at(dig_off, pdrm_pkg::POS_DIGITAL_OFF) | bit_at(cal_hold, pdrm_pkg::POS_CAL_HOLD);
    assign rd_r0h  = lim0_high;
    assign rd_r0l  = lim0_low;
    assign rd_r1t  = bit_at(lim1_top, pdrm_pkg::POS_LIMIT_TOP);
    assign rd_r1h  = lim1_high;
    assign rd_r1l  = lim1_low;

    // Reserved bytes and bits read as zero, though software must not count on it
    always_comb begin
        next_rdata = 8'h00;
        case (acc.addr)
            pdrm_pkg::ADDR_XTAL_CTRL: next_rdata = rd_xtal;
            pdrm_pkg::ADDR_REF_DIS:   next_rdata = rd_ref;
            pdrm_pkg::ADDR_OUT_DIS:   next_rdata = rd_out;
            pdrm_pkg::ADDR_LOOP_DIS:  next_rdata = rd_loop;
            pdrm_pkg::ADDR_REF0_HIGH: next_rdata = rd_r0h;
            pdrm_pkg::ADDR_REF0_LOW:  next_rdata = rd_r0l;
            pdrm_pkg::ADDR_REF1_TOP:  next_rdata = rd_r1t;
            pdrm_pkg::ADDR_REF1_HIGH: next_rdata = rd_r1h;
            pdrm_pkg::ADDR_REF1_LOW:  next_rdata = rd_r1l;
            default:                  next_rdata = 8'h00;
        endcase
    end

    assign next_rvalid = acc.rd && in_bank;

    // Each byte lands on its own write; no commit step is needed
    always_ff @(posedge clk) begin
        if (reset) begin
            doubler_bypass <= pdrm_pkg::RST_DOUBLER_BYPASS;
        end else if (w_xtal) begin
            doubler_bypass <= next_doubler_bypass;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ref_off <= pdrm_pkg::RST_REF_INPUT_OFF;
        end else if (w_ref) begin
            ref_off <= next_ref_off;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            drv_off <= pdrm_pkg::RST_OUT_DRIVER_OFF;
        end else if (w_out) begin
            drv_off <= next_drv_off;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dig_off  <= pdrm_pkg::RST_DIGITAL_OFF;
            cal_hold <= pdrm_pkg::RST_CAL_HOLD;
        end else if (w_loop) begin
            dig_off  <= next_dig_off;
            cal_hold <= next_cal_hold;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            lim0_high <= pdrm_pkg::RST_MISS_LIMIT[15:8];
        end else if (w_r0h) begin
            lim0_high <= next_lim_byte;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            lim0_low <= pdrm_pkg::RST_MISS_LIMIT[7:0];
        end else if (w_r0l) begin
            lim0_low <= next_lim_byte;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            lim1_top <= pdrm_pkg::RST_MISS_LIMIT[16];
        end else if (w_r1t) begin
            lim1_top <= next_lim1_top;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            lim1_high <= pdrm_pkg::RST_MISS_LIMIT[15:8];
        end else if (w_r1h) begin
            lim1_high <= next_lim_byte;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            lim1_low <= pdrm_pkg::RST_MISS_LIMIT[7:0];
        end else if (w_r1l) begin
            lim1_low <= next_lim_byte;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rvalid <= 1'b0;
        end else begin
            rvalid <= next_rvalid;
        end
    end

    // Holds the last byte read until the next read strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= 8'h00;
        end else if (acc.rd) begin
            rdata <= next_rdata;
        end
    end

    // Reference 0 has no bit 16 register, so its top bit stays zero
    assign lim0 = {1'b0, lim0_high, lim0_low};
    assign lim1 = {lim1_top, lim1_high, lim1_low};

    assign ctrl = '{
        xtal_doubler_bypass: doubler_bypass,
        ref_input_off:       ref_off,
        out_driver_off:      drv_off,
        digital_loop_off:    dig_off,
        analog_cal_hold:     cal_hold,
        ref0_miss_limit:     lim0,
        ref1_miss_limit:     lim1
    };

    // Status hint only; the monitor still uses whatever was written
    assign limit_below_min = limit_too_small(lim0) || limit_too_small(lim1);
endmodule

// ### verif/pdrm_regs_asserts.sv
// Port assertions for the power-down and miss-limit registers
`timescale 1ns/1ns
module pdrm_regs_asserts (
    input wire logic                   clk,
    input wire logic                   reset,
    input wire pdrm_pkg::pdrm_access_t acc,
    input wire logic [7:0]             rdata,
    input wire logic                   rvalid,
    input wire logic                   hit,
    input wire pdrm_pkg::pdrm_ctrl_t   ctrl,
    input wire logic                   limit_below_min
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_doubler_write: assert property (acc.wr && acc.addr == 16'h00b4 |=>
        ctrl.xtal_doubler_bypass == $past(acc.wdata[0])) else $error("doubler bit missed a write");
    a_loop_write: assert property (acc.wr && acc.addr == 16'h00b8 |=>
        ctrl.digital_loop_off == $past(acc.wdata[2])) else $error("loop off bit missed a write");
    a_cal_write: assert property (acc.wr && acc.addr == 16'h00b8 |=>
        ctrl.analog_cal_hold == $past(acc.wdata[0])) else $error("cal hold bit missed a write");
    a_ref1_top: assert property (acc.wr && acc.addr == 16'h00bc |=>
        ctrl.ref1_miss_limit[16] == $past(acc.wdata[0])) else $error("ref1 limit bit 16 wrong");
    a_limit_flag: assert property (limit_below_min == (ctrl.ref0_miss_limit < 17'h00003 ||
        ctrl.ref1_miss_limit < 17'h00003)) else $error("limit flag disagrees with limits");
    a_read_answer: assert property (acc.rd |=> rvalid == $past(hit))
        else $error("read answer pulse wrong");
    a_reset_defaults: assert property ($past(reset) |-> ctrl.digital_loop_off && ctrl.analog_cal_hold &&
        ctrl.ref_input_off == 2'h3 && ctrl.out_driver_off == 8'hf0) else $error("defaults lost at reset");
endmodule

// ### verif/pdrm_regs_tb.sv
// Self-checking bench for the power-down and miss-limit registers
`timescale 1ns/1ns
module pdrm_regs_tb;
    logic                   clk = 1'b0;
    logic                   reset = 1'b1;
    pdrm_pkg::pdrm_access_t acc = '0;
    logic [7:0]             rdata;
    logic                   rvalid, hit, limit_below_min;
    pdrm_pkg::pdrm_ctrl_t   ctrl;
    int                     miscompares = 0, comparisons = 0, cycles = 0;
    logic [7:0]             dflt [11] = '{8'h00, 8'h03, 8'h00, 8'hf0, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    pdrm_regs uut (.clk(clk), .reset(reset), .acc(acc), .rdata(rdata), .rvalid(rvalid), .hit(hit),
                   .ctrl(ctrl), .limit_below_min(limit_below_min));
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // A spare cycle after each access keeps strobes from being driven twice in one step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk) acc <= '{1'b1, 1'b0, a, d};
        @(posedge clk) acc <= '0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [8:0] e);
        @(posedge clk) acc <= '{1'b0, 1'b1, a, 8'h00};
        #1 check(32'(hit), 32'(e[8]));
        @(posedge clk) acc <= '0;
        #1 check(32'({rvalid, rdata}), 32'(e));
    endtask
    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        foreach (dflt[i]) rd(16'(16'h00b4 + i), {1'b1, dflt[i]});
        check(32'(limit_below_min), 32'h1);
        rd(16'h00bf, 9'h000);
        wr(16'h00b4, 8'h01);
        check(32'(ctrl.xtal_doubler_bypass), 32'h1);
        rd(16'h00b4, 9'h101);
        wr(16'h00b8, 8'h04);
        check(32'({ctrl.digital_loop_off, ctrl.analog_cal_hold}), 32'h2);
        wr(16'h00b8, 8'h01);
        check(32'({ctrl.digital_loop_off, ctrl.analog_cal_hold}), 32'h1);
        rd(16'h00b8, 9'h101);
        wr(16'h00b5, 8'h02);
        wr(16'h00b7, 8'ha5);
        check(32'({ctrl.ref_input_off, ctrl.out_driver_off}), 32'h2a5);
        wr(16'h00b6, 8'h00);
        rd(16'h00b6, 9'h100);
        wr(16'h00bc, 8'h01);
        wr(16'h00bd, 8'h56);
        wr(16'h00be, 8'h78);
        check(32'(ctrl.ref1_miss_limit), 32'h15678);
        rd(16'h00bc, 9'h101);
        wr(16'h00bb, 8'h02);
        check(32'(limit_below_min), 32'h1);
        wr(16'h00bb, 8'h03);
        check(32'(limit_below_min), 32'h0);
        wr(16'h00ba, 8'h12);
        check(32'(ctrl.ref0_miss_limit), 32'h01203);
        @(posedge clk) reset <= 1'b1;
        @(posedge clk) reset <= 1'b0;
        foreach (dflt[i]) rd(16'(16'h00b4 + i), {1'b1, dflt[i]});
        complete_run();
    end
endmodule
bind pdrm_regs pdrm_regs_asserts chk (.clk(clk), .reset(reset), .acc(acc), .rdata(rdata), .rvalid(rvalid),
    .hit(hit), .ctrl(ctrl), .limit_below_min(limit_below_min));
